/* src/fsal_cfg.svh */
// fsal_cfg.svh: bit positions, timing and reset constants of the
// frequency status and alarm latch.
// assumes: included by its bare name from the package and the module.
//
// How it works
// - status bit 0 high while frequency refreshed
// - status bit 1 high while ratio refreshed
// - status bit 2 high while angle refreshed
// - status bit 5 set after one silent second
// - status bit 6 when frequency below sampling rate
// - too slow keeps frequency delivered and valid
// - status bit 7 at 80 percent of bandwidth
// - bandwidth follows the configured input filter
// - alarms stay latched until software clears them
// - alarm bit 4 latches the halted input
// - alarm bit 5 latches the too slow input
// - alarm bit 6 latches the too fast input
// - alarm bit 7 latches frequency below limits
// - alarm bit 8 latches frequency inside window
// - alarm bit 9 latches frequency above limits
// - command bit 6 clears and disables all alarms
// - command bits 7 to 12 clear single alarms
// - alarm changes flagged on both edges
`ifndef FSAL_CFG_SVH
`define FSAL_CFG_SVH

// ******************************************************
// status word bits
// ******************************************************
`define FSAL_ST_FREQ_VALID  0
`define FSAL_ST_RATIO_VALID 1
`define FSAL_ST_ANGLE_VALID 2
`define FSAL_ST_HALTED      5
`define FSAL_ST_TOO_SLOW    6
`define FSAL_ST_TOO_FAST    7

// ******************************************************
// alarm bits and clear command bits
// ******************************************************
`define FSAL_ALARM_LSB      4
`define FSAL_ALARM_COUNT    6
`define FSAL_CLR_ALL        6
`define FSAL_CLR_LSB        7
`define FSAL_WORD_RESET     16'h0000

// ******************************************************
// timing
// ******************************************************
`define FSAL_CORE_CLK_HZ    64'd25000000
`define FSAL_HALT_TIME_MS   64'd1000
`define FSAL_HALT_CYCLES    ((`FSAL_HALT_TIME_MS * `FSAL_CORE_CLK_HZ) / 64'd1000)
`define FSAL_REFRESH_CYCLES `FSAL_HALT_CYCLES
`define FSAL_FAST_PERCENT   80

// ******************************************************
// bandwidth of each input filter setting, in Hz
// ******************************************************
`define FSAL_FILTER_BW0_HZ  32'h000F4240
`define FSAL_FILTER_BW1_HZ  32'h00009C40
`define FSAL_FILTER_BW2_HZ  32'h00001388
`define FSAL_FILTER_BW3_HZ  32'h000003E8

`endif

/* src/fsal_pkg.sv */
// fsal_pkg.sv: types shared by the frequency status and alarm latch.
// assumes: fsal_cfg.svh is on the include path.
`include "fsal_cfg.svh"

package fsal_pkg;

	typedef logic [15:0] fsal_word_t;
	typedef logic [31:0] fsal_freq_t;
	typedef logic [1:0]  fsal_filter_t;

	typedef enum logic [1:0] {
		FSAL_CMP_NONE   = 2'b00,
		FSAL_CMP_BELOW  = 2'b01,
		FSAL_CMP_WINDOW = 2'b10,
		FSAL_CMP_ABOVE  = 2'b11
	} fsal_cmp_t;

endpackage : fsal_pkg

/* src/fsal_top.sv */
// fsal_top.sv: validity status, limit detection and latched alarms
// for one frequency measurement channel.
// assumes: result strobes and values come synchronous to core_clk from
// the measurement engine; the host reads the words and writes the
// clear commands once per task cycle.
`timescale 1ns/10ps
`default_nettype none
`include "fsal_cfg.svh"

module fsal_top #(
	parameter longint unsigned HALT_CYCLES    = `FSAL_HALT_CYCLES,
	parameter longint unsigned REFRESH_CYCLES = `FSAL_REFRESH_CYCLES
) (
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire logic                 input_edge,
	input  wire logic                 freq_result_strobe,
	input  wire fsal_pkg::fsal_freq_t freq_value,
	input  wire logic                 ratio_result_strobe,
	input  wire logic                 angle_result_strobe,
	input  wire fsal_pkg::fsal_freq_t sample_rate_hz,
	input  wire fsal_pkg::fsal_filter_t filter_sel,
	input  wire fsal_pkg::fsal_freq_t low_limit,
	input  wire fsal_pkg::fsal_freq_t high_limit,
	input  wire fsal_pkg::fsal_word_t alarm_clear_commands,
	output var  fsal_pkg::fsal_word_t measurement_status_word,
	output var  fsal_pkg::fsal_word_t alarm_input_bits,
	output var  fsal_pkg::fsal_word_t alarm_change
);
	import fsal_pkg::*;

	localparam int NA = `FSAL_ALARM_COUNT;
	localparam logic [31:0] HALT_LIM = 32'(HALT_CYCLES);
	localparam logic [31:0] REFR_LIM = 32'(REFRESH_CYCLES);

	// ******************************************************
	// halted input detection
	// ******************************************************
	logic [31:0] halt_cnt;
	logic [31:0] next_halt_cnt;
	logic        halted;

	always_comb begin
		if (input_edge) begin
			next_halt_cnt = 32'h00000000;
		end else if (halt_cnt == HALT_LIM) begin
			next_halt_cnt = halt_cnt;
		end else begin
			next_halt_cnt = halt_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			halt_cnt <= 32'h00000000;
		end else begin
			halt_cnt <= next_halt_cnt;
		end
	end

	// counter saturates, so silence of any length stays halted
	assign halted = (halt_cnt == HALT_LIM);

	// ******************************************************
	// refresh watchdogs: 0 frequency, 1 ratio, 2 angle
	// ******************************************************
	logic [2:0]  res_strobe;
	logic        valid [3];
	logic        next_valid [3];
	logic [31:0] wd_cnt [3];
	logic [31:0] next_wd_cnt [3];

	assign res_strobe = {angle_result_strobe, ratio_result_strobe,
		freq_result_strobe};

	for (genvar i = 0; i < 3; i++) begin : g_wd
		always_comb begin
			next_wd_cnt[i] = wd_cnt[i];
			next_valid[i]  = valid[i];
			if (res_strobe[i]) begin
				next_wd_cnt[i] = 32'h00000000;
				next_valid[i]  = 1'b1;
			end else if (wd_cnt[i] == REFR_LIM) begin
				next_valid[i]  = 1'b0;
			end else begin
				next_wd_cnt[i] = wd_cnt[i] + 32'h00000001;
			end
			// a stopped input ends frequency validity, too slow does not
			if (i == 0 && halted && !res_strobe[i]) begin
				next_valid[i] = 1'b0;
			end
		end

		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				wd_cnt[i] <= 32'h00000000;
				valid[i]  <= 1'b0;
			end else begin
				wd_cnt[i] <= next_wd_cnt[i];
				valid[i]  <= next_valid[i];
			end
		end
	end

	// ******************************************************
	// limit checks on each frequency result
	// ******************************************************
	logic [31:0] bw_hz;
	logic [38:0] freq_x100;
	logic [38:0] bw_x80;
	logic        slow_now;
	logic        fast_now;
	logic        too_slow;
	logic        too_fast;
	logic        next_too_slow;
	logic        next_too_fast;

	always_comb begin
		unique case (filter_sel)
			2'h0:    bw_hz = `FSAL_FILTER_BW0_HZ;
			2'h1:    bw_hz = `FSAL_FILTER_BW1_HZ;
			2'h2:    bw_hz = `FSAL_FILTER_BW2_HZ;
			2'h3:    bw_hz = `FSAL_FILTER_BW3_HZ;
		endcase
	end

	// percentages compared as products, no divider needed
	// full 39 bits, a large frequency must not wrap below the bound
	assign freq_x100 = 39'(freq_value) * 39'd100;
	assign bw_x80    = 39'(bw_hz) * 39'(`FSAL_FAST_PERCENT);
	assign slow_now  = (freq_value < sample_rate_hz);
	assign fast_now  = (freq_x100 >= bw_x80);

	always_comb begin
		next_too_slow = too_slow;
		next_too_fast = too_fast;
		if (freq_result_strobe) begin
			next_too_slow = slow_now;
			next_too_fast = fast_now;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			too_slow <= 1'b0;
			too_fast <= 1'b0;
		end else begin
			too_slow <= next_too_slow;
			too_fast <= next_too_fast;
		end
	end

	// ******************************************************
	// compare function against configured limits
	// ******************************************************
	fsal_cmp_t cmp_state;
	fsal_cmp_t next_cmp_state;
	fsal_cmp_t cmp_now;

	// below is checked first, so crossed limits still give one answer
	always_comb begin
		if (freq_value < low_limit) begin
			cmp_now = FSAL_CMP_BELOW;
		end else if (freq_value > high_limit) begin
			cmp_now = FSAL_CMP_ABOVE;
		end else begin
			cmp_now = FSAL_CMP_WINDOW;
		end
		next_cmp_state = freq_result_strobe ? cmp_now : cmp_state;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmp_state <= FSAL_CMP_NONE;
		end else begin
			cmp_state <= next_cmp_state;
		end
	end

	// ******************************************************
	// alarm latches
	// ******************************************************
	logic [NA-1:0] alarm_event;
	logic [NA-1:0] alarm_clr;
	logic [NA-1:0] alarm_latch;
	logic [NA-1:0] next_alarm_latch;
	logic          cmp_below;
	logic          cmp_window;
	logic          cmp_above;

	always_comb begin
		cmp_below  = 1'b0;
		cmp_window = 1'b0;
		cmp_above  = 1'b0;
		unique case (cmp_state)
			FSAL_CMP_NONE:   cmp_below  = 1'b0;
			FSAL_CMP_BELOW:  cmp_below  = 1'b1;
			FSAL_CMP_WINDOW: cmp_window = 1'b1;
			FSAL_CMP_ABOVE:  cmp_above  = 1'b1;
		endcase
	end

	assign alarm_event = {cmp_above, cmp_window, cmp_below,
		too_fast, too_slow, halted};
	assign alarm_clr = alarm_clear_commands[`FSAL_CLR_LSB +: NA]
		| {NA{alarm_clear_commands[`FSAL_CLR_ALL]}};

	// a held clear both empties and disables; release re-arms
	always_comb begin
		next_alarm_latch = (alarm_latch | alarm_event) & ~alarm_clr;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			alarm_latch <= '0;
		end else begin
			alarm_latch <= next_alarm_latch;
		end
	end

	// ******************************************************
	// host visible words
	// ******************************************************
	fsal_word_t next_status;
	fsal_word_t next_alarm_word;
	fsal_word_t next_change;

	always_comb begin
		next_status = `FSAL_WORD_RESET;
		next_status[`FSAL_ST_FREQ_VALID]  = valid[0];
		next_status[`FSAL_ST_RATIO_VALID] = valid[1];
		next_status[`FSAL_ST_ANGLE_VALID] = valid[2];
		next_status[`FSAL_ST_HALTED]      = halted;
		next_status[`FSAL_ST_TOO_SLOW]    = too_slow;
		next_status[`FSAL_ST_TOO_FAST]    = too_fast;
		next_alarm_word = `FSAL_WORD_RESET;
		next_alarm_word[`FSAL_ALARM_LSB +: NA] = next_alarm_latch;
		// either edge of any alarm bit marks an event
		next_change = next_alarm_word ^ alarm_input_bits;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			measurement_status_word <= `FSAL_WORD_RESET;
			alarm_input_bits        <= `FSAL_WORD_RESET;
			alarm_change            <= `FSAL_WORD_RESET;
		end else begin
			measurement_status_word <= next_status;
			alarm_input_bits        <= next_alarm_word;
			alarm_change            <= next_change;
		end
	end

	// ******************************************************
	// assertions
	// ******************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_FREQ_VALID_SHOWN: assert property (
		freq_result_strobe |-> ##2 measurement_status_word[0])
		else $error("frequency result not shown valid");

	AST_FREQ_HALT_INVALID: assert property (
		(halted && !freq_result_strobe) |=> ##1 !measurement_status_word[0])
		else $error("frequency valid while input halted");

	AST_RATIO_VALID: assert property (
		ratio_result_strobe |=> valid[1] ##1 measurement_status_word[1])
		else $error("ratio not marked valid after result");

	AST_ANGLE_TIMEOUT: assert property (
		(valid[2] && wd_cnt[2] == REFR_LIM && !angle_result_strobe)
		|=> !valid[2])
		else $error("angle valid after refresh timeout");

	AST_HALT_STATUS: assert property (
		(halt_cnt == HALT_LIM - 32'h00000001 && !input_edge)
		|=> halted ##1 measurement_status_word[5])
		else $error("halted status not set after silence");

	AST_EDGE_UNHALTS: assert property (
		input_edge |=> !halted)
		else $error("halted despite input edge");

	AST_TOO_SLOW: assert property (
		(freq_result_strobe && freq_value < sample_rate_hz)
		|=> too_slow ##1 measurement_status_word[6])
		else $error("too slow not flagged");

	AST_SLOW_STILL_VALID: assert property (
		(too_slow && valid[0] && !halted && wd_cnt[0] != REFR_LIM)
		|=> valid[0])
		else $error("slow result not valid");

	AST_TOO_FAST: assert property (
		(freq_result_strobe
		 && 39'(freq_value) * 39'd100 >= 39'(bw_hz) * 39'd80)
		|=> too_fast ##1 measurement_status_word[7])
		else $error("too fast not flagged");

	AST_ALARM_HOLDS: assert property (
		(alarm_latch[0] && !alarm_clr[0]) |=> alarm_latch[0])
		else $error("halted alarm dropped without clear");

	AST_HALT_ALARM: assert property (
		(halted && !alarm_clr[0]) |=> alarm_input_bits[4])
		else $error("halted alarm bit not latched");

	AST_CMP_ALARM: assert property (
		(freq_result_strobe && cmp_now == FSAL_CMP_WINDOW)
		##1 !alarm_clr[4] |=> alarm_input_bits[8])
		else $error("window alarm not latched");

	AST_CMP_ONEHOT: assert property (
		(freq_result_strobe && freq_value >= low_limit
		 && freq_value <= high_limit)
		|=> cmp_window && !cmp_below && !cmp_above)
		else $error("compare results not exclusive");

	AST_CLEAR_ALL: assert property (
		alarm_clear_commands[6][*2] |-> alarm_input_bits[9:4] == 6'h00)
		else $error("alarms present under clear all");

	AST_CLEAR_ONE: assert property (
		alarm_clear_commands[12] |=> !alarm_input_bits[9])
		else $error("above alarm present under its clear");

	AST_CHANGE_EDGES: assert property (
		alarm_change == (alarm_input_bits ^ $past(alarm_input_bits)))
		else $error("alarm change does not match edges");

	COV_HALT: cover property ($rose(measurement_status_word[5]));
	COV_ALARM_FALL: cover property (
		alarm_input_bits[5] ##1 !alarm_input_bits[5] && alarm_change[5]);
	COV_WINDOW: cover property ($rose(alarm_input_bits[8]));
	COV_FAST: cover property ($rose(measurement_status_word[7]));

endmodule : fsal_top
`default_nettype wire

/* sim/fsal_host_model.sv */
// fsal_host_model.sv: host task that writes alarm clear commands and
// samples the alarm word once per task cycle.
// assumes: the bench posts commands on cmd_req; a task cycle is TASK_CYC
// clocks long.
`timescale 1ns/10ps
`default_nettype none
module fsal_host_model #(
	parameter int TASK_CYC = 4
) (
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire fsal_pkg::fsal_word_t cmd_req,
	input  wire fsal_pkg::fsal_word_t alarm_input_bits,
	output var  fsal_pkg::fsal_word_t alarm_clear_commands,
	output var  fsal_pkg::fsal_word_t alarm_seen
);
	import fsal_pkg::*;
	int cnt;
	// ****************************************************
	// periodic task
	// ****************************************************
	// nothing moves between task boundaries, so a clear is never faster
	// than one task cycle
	always @(negedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt = 0;
			alarm_clear_commands <= 16'h0000;
			alarm_seen <= 16'h0000;
		end else if (cnt == TASK_CYC - 1) begin
			cnt = 0;
			alarm_seen <= alarm_input_bits;
			alarm_clear_commands <= cmd_req & 16'h1FC0;
		end else begin
			cnt = cnt + 1;
		end
	end
endmodule : fsal_host_model
`default_nettype wire

/* sim/testbench.sv */
// testbench.sv: self-checking bench for the status and alarm latch.
// assumes: short halt and refresh counts; host model issues clears.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fsal_pkg::*;
	logic       core_clk, rstn, input_edge, edge_en;
	logic       freq_result_strobe, ratio_result_strobe, angle_result_strobe;
	fsal_freq_t freq_value, sample_rate_hz, low_limit, high_limit;
	fsal_filter_t filter_sel;
	fsal_word_t cmd_req, clr, st, al, ch, seen, last_ch, exp_al;
	fsal_freq_t bw [4] = '{32'h000F4240, 32'h00009C40, 32'h00001388,
		32'h000003E8};
	int failures, n_checks, k;

	fsal_top #(.HALT_CYCLES(20), .REFRESH_CYCLES(30)) uut (
		.core_clk(core_clk), .rstn(rstn), .input_edge(input_edge),
		.freq_result_strobe(freq_result_strobe), .freq_value(freq_value),
		.ratio_result_strobe(ratio_result_strobe),
		.angle_result_strobe(angle_result_strobe),
		.sample_rate_hz(sample_rate_hz), .filter_sel(filter_sel),
		.low_limit(low_limit), .high_limit(high_limit),
		.alarm_clear_commands(clr), .measurement_status_word(st),
		.alarm_input_bits(al), .alarm_change(ch));

	fsal_host_model #(.TASK_CYC(4)) host (
		.core_clk(core_clk), .rstn(rstn), .cmd_req(cmd_req),
		.alarm_input_bits(al), .alarm_clear_commands(clr),
		.alarm_seen(seen));

	always #20 core_clk = ~core_clk;
	// measured input keeps toggling until the halt test stops it
	always @(negedge core_clk) input_edge <= edge_en & ~input_edge;

	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic check(input fsal_word_t s, input fsal_word_t e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check

	// strobe at c0, results settled after c2
	task automatic pulse(input fsal_freq_t f, input logic ra);
		@(negedge core_clk);
		freq_value = f;
		freq_result_strobe = 1'b1;
		ratio_result_strobe = ra;
		angle_result_strobe = ra;
		@(negedge core_clk);
		freq_result_strobe = 1'b0;
		ratio_result_strobe = 1'b0;
		angle_result_strobe = 1'b0;
		// change flags stand one cycle only, caught while they stand
		@(negedge core_clk);
		last_ch = ch;
		@(negedge core_clk);
	endtask : pulse

	task automatic host_cmd(input fsal_word_t v);
		int n;
		// non-blocking, so the host model never races this write
		cmd_req <= v;
		for (n = 0; n < 20 && clr !== v; n++) @(negedge core_clk);
		if (clr !== v) begin
			failures++;
			give_verdict();
		end
		last_ch = ch;
		repeat (3) @(negedge core_clk);
	endtask : host_cmd

	initial begin
		core_clk = 1'b0; rstn = 1'b0; edge_en = 1'b1; input_edge = 1'b0;
		freq_result_strobe = 1'b0; ratio_result_strobe = 1'b0;
		angle_result_strobe = 1'b0; freq_value = 32'h00000000;
		sample_rate_hz = 32'h00000064; filter_sel = 2'h3;
		low_limit = 32'h000000C8; high_limit = 32'h00000190;
		cmd_req = 16'h0000; failures = 0; n_checks = 0;
		repeat (4) @(negedge core_clk);
		rstn = 1'b1;
		check(st | al | ch, 16'h0000);
		pulse(32'h00000032, 1'b1);
		check(st & 16'h00E7, 16'h0047);
		check(al, 16'h00A0);
		check(last_ch, 16'h00A0);
		pulse(32'h0000031F, 1'b0);
		check(st & 16'h00E7, 16'h0007);
		check(al, 16'h02A0);
		check(last_ch, 16'h0200);
		for (k = 0; k < 4; k++) begin
			filter_sel = k[1:0];
			pulse(bw[k] / 10 * 8, 1'b0);
			check(st & 16'h0081, 16'h0081);
			pulse(bw[k] / 10 * 8 - 1, 1'b0);
			check(st & 16'h0081, 16'h0001);
		end
		check(al, 16'h02E0);
		pulse(32'h0000012C, 1'b0);
		check(al, 16'h03E0);
		check(last_ch, 16'h0100);
		exp_al = 16'h03E0;
		for (k = 0; k < 6; k++) begin
			host_cmd(16'h0080 << k);
			repeat (4) @(negedge core_clk);
			exp_al = exp_al & ~(16'h0010 << k);
			check(al, exp_al);
			if (k == 4)
				check(last_ch, 16'h0100);
			host_cmd(16'h0000);
			if (k == 4)
				exp_al = exp_al | 16'h0100;
			check(al, exp_al);
		end
		check(seen, 16'h0100);
		pulse(32'h00000032, 1'b0);
		check(al, 16'h01A0);
		host_cmd(16'h0040);
		check(al, 16'h0000);
		repeat (6) @(negedge core_clk);
		check(al, 16'h0000);
		host_cmd(16'h0000);
		check(al, 16'h00A0);
		// fresh result, so only the halt can end frequency validity
		pulse(32'h00000032, 1'b0);
		edge_en <= 1'b0;
		repeat (15) @(negedge core_clk);
		check(st & 16'h0021, 16'h0001);
		for (k = 0; k < 15 && st[5] !== 1'b1; k++) @(negedge core_clk);
		if (st[5] !== 1'b1) begin
			failures++;
			give_verdict();
		end
		repeat (3) @(negedge core_clk);
		check(st & 16'h0021, 16'h0020);
		check(al & 16'h0010, 16'h0010);
		repeat (40) @(negedge core_clk);
		check(st & 16'h0007, 16'h0000);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
